// File: hdl/smpc_pkg.sv
package smpc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h00;
  localparam logic [7:0] ADDR_POWER_RED = 8'h04;
  localparam logic [7:0] ADDR_INDIS_LO = 8'h08;
  localparam logic [7:0] ADDR_INDIS_HI = 8'h0C;
  localparam logic [7:0] ADDR_ANALOG_CFG = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_WAKE_CFG = 8'h18;

  // ----------------------------------------------------------------
  // field layout and resets
  // ----------------------------------------------------------------
  localparam int SE_BIT = 0;
  localparam int SM_LSB = 1;
  localparam logic [7:0] SLEEP_CTRL_MASK = 8'h07;
  localparam logic [7:0] POWER_RED_MASK = 8'h3F;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // analog cfg bits
  localparam int ACFG_ADC_EN = 0;
  localparam int ACFG_CMP_EN = 1;
  localparam int ACFG_CMP_IREF = 2;
  localparam logic [7:0] ANALOG_CFG_MASK = 8'h07;
  localparam logic [3:0] WAKE_CFG_RESET = 4'h0;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  localparam int NUM_PERIPH = 6;

  // ----------------------------------------------------------------
  // sleep mode encodings and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] SM_IDLE = 2'b00;
  localparam logic [1:0] SM_ADC_NR = 2'b01;
  localparam logic [1:0] SM_PDOWN = 2'b10;
  localparam logic [1:0] SM_PSAVE = 2'b11;
  localparam int CLK_HZ = 10_000_000;
  localparam int HALT_EXTRA_CYC = 4;
  localparam int WAKE_UNIT_NS = 1_000;
  localparam int WAKE_UNIT_CYC = (WAKE_UNIT_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;
  localparam logic [15:0] WAKE_BASE_CYC = 16'(WAKE_UNIT_CYC * 16);

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE = 2'b11,
    ST_HALT = 2'b10
  } smpc_state_t;

endpackage

// File: hdl/smpc_ctrl.sv
`timescale 1ns/1ps
// What this block does
// RULE1: sleep field 10 enters power-down
// RULE2: power-down stops oscillator and all clocks
// RULE3: only listed events wake from power-down
// RULE4: level wake source holds level long enough
// RULE5: wake delay chosen by clock-select setting
// RULE6: sleep field 11 enters power-save
// RULE7: async timer irq wakes if enables set
// RULE8: software prefers power-down without async timer
// RULE9: power-save keeps only async timer clock
// RULE10: reduction bit stops clock, blocks access
// RULE11: clearing reduction bit resumes peripheral state
// RULE12: software disables peripheral before gating
// RULE13: gating acts in active and idle
// RULE14: converter stays on; relaunch gives extended
// RULE15: comparator off in deep modes; reference kept
// RULE16: reference on when any user needs it
// RULE17: enabled brown-out detector stays on
// RULE18: enabled watchdog keeps running in sleep
// RULE19: deep modes disable input buffers except wake
// RULE20: disable registers turn off analog buffers
// RULE21: debug link keeps main clock running
// RULE22: sleep control bits 7..3 read zero
// RULE23: sleep only when sleep-enable bit set
// RULE24: field 00 idle, 01 noise reduction
// RULE25: core halted four cycles after start-up
// RULE26: wake delay down-counter, release at zero
module smpc_ctrl
  import smpc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core side
  input wire logic sleep_instr,
  input wire logic global_irq_enable,
  output logic core_halt,
  output logic core_irq_resume,
  // configuration straps
  input wire logic [3:0] clock_select_config,
  input wire logic brownout_level_config,
  input wire logic debug_link_enable_config,
  input wire logic watchdog_enable,
  // timer zero
  input wire logic timer0_async_select,
  input wire logic [1:0] timer0_irq_mask,
  input wire logic [1:0] timer0_event,
  // asynchronous wake events (pins)
  input wire logic ext_reset_req,
  input wire logic watchdog_reset_req,
  input wire logic watchdog_irq,
  input wire logic brownout_reset_req,
  input wire logic serial_start_irq,
  input wire logic ext_irq_line_a,
  input wire logic ext_irq_line_b,
  input wire logic pin_change_irq,
  input wire logic other_irq,
  // clock domain enables
  output logic osc_enable,
  output logic cpu_clk_en,
  output logic io_clk_en,
  output logic adc_clk_en,
  output logic async_timer_clock_en,
  output logic [5:0] periph_clk_en,
  output logic [5:0] periph_access_en,
  // analogue and pins
  output logic adc_enable,
  output logic adc_extended_conv,
  output logic cmp_enable,
  output logic vref_enable,
  output logic brownout_enable,
  output logic watchdog_run,
  output logic input_buf_en,
  output logic wake_pin_buf_en,
  output logic [7:0] input_disable_lo,
  output logic [7:0] input_disable_hi
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    smpc_state_t st;
    logic [1:0] mode;
    logic [15:0] wake_cnt;
    logic [2:0] halt_cnt;
    logic [7:0] sleep_ctrl;
    logic [7:0] power_red;
    logic [7:0] indis_lo;
    logic [7:0] indis_hi;
    logic [7:0] analog_cfg;
    logic [3:0] wake_cfg;
    logic adc_was_off;
    logic irq_wake;
    logic [8:0] sync1;
    logic [8:0] sync2;
    logic awok;
    logic wok;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } smpc_regs_t;

  smpc_regs_t r;
  smpc_regs_t next_r;

  // delay per clock-select code: base times (code+1)
  function automatic logic [15:0] wake_delay(input logic [3:0] code);
    wake_delay = 16'(WAKE_BASE_CYC * ({12'h000, code} + 16'h0001));
  endfunction

  function automatic logic deep_mode(input smpc_state_t s, input logic [1:0] m);
    deep_mode = (s != ST_RUN) && (s != ST_HALT) && (m[1] == 1'b1);
  endfunction

  logic asleep;
  logic deep;
  logic wake_pd;
  logic wake_ps;
  logic wake_light;
  logic [8:0] ev_raw;
  logic [8:0] ev;
  logic t0_wake;

  assign ev_raw = {other_irq, pin_change_irq, ext_irq_line_b, ext_irq_line_a,
                   serial_start_irq, brownout_reset_req, watchdog_irq,
                   watchdog_reset_req, ext_reset_req};
  // only the second stage is read
  assign ev = r.sync2;
  assign asleep = (r.st == ST_SLEEP);
  assign deep = deep_mode(r.st, r.mode);
  // level lines are sampled synchronously, so a short glitch is missed [RULE4]
  assign wake_pd = |ev[7:0]; // [RULE3]
  // timer events come from the async timer domain logic on aclk
  assign t0_wake = timer0_async_select && global_irq_enable
                   && (|(timer0_irq_mask & timer0_event)); // [RULE7]
  assign wake_ps = wake_pd || t0_wake; // [RULE6]
  assign wake_light = wake_pd || t0_wake || ev[8];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] rd;
    logic [7:0] wb;
    rd = 32'h0000_0000;
    wb = 8'h00;
    next_r = r;
    next_r.sync1 = ev_raw;
    next_r.sync2 = r.sync1;

    // power state machine
    case (r.st)
      ST_RUN: begin
        if (sleep_instr && r.sleep_ctrl[SE_BIT]) begin // [RULE23]
          next_r.st = ST_SLEEP;
          next_r.mode = r.sleep_ctrl[SM_LSB +: 2]; // [RULE1] [RULE6] [RULE24]
        end
      end
      ST_SLEEP: begin
        if ((r.mode == SM_PDOWN && wake_pd) || (r.mode == SM_PSAVE && wake_ps)) begin
          next_r.st = ST_WAKE;
          next_r.wake_cnt = wake_delay(clock_select_config); // [RULE5] [RULE26]
          next_r.irq_wake = 1'b1;
        end else if ((r.mode == SM_IDLE && wake_light) || (r.mode == SM_ADC_NR && wake_ps)) begin
          next_r.st = ST_HALT;
          next_r.halt_cnt = 3'(HALT_EXTRA_CYC);
          next_r.irq_wake = 1'b1;
        end
      end
      ST_WAKE: begin
        if (r.wake_cnt == 16'h0000) begin // [RULE26]
          next_r.st = ST_HALT;
          next_r.halt_cnt = 3'(HALT_EXTRA_CYC); // [RULE25]
        end else begin
          next_r.wake_cnt = r.wake_cnt - 16'h0001;
        end
      end
      ST_HALT: begin
        if (r.halt_cnt == 3'h1) begin
          next_r.st = ST_RUN;
          next_r.irq_wake = 1'b0;
        end else begin
          next_r.halt_cnt = r.halt_cnt - 3'h1; // [RULE25]
        end
      end
      default: begin
        next_r.st = ST_RUN;
      end
    endcase

    // converter off then on forces extended conversion
    if (!r.analog_cfg[ACFG_ADC_EN]) begin
      next_r.adc_was_off = 1'b1; // [RULE14]
    end else if (sleep_instr && r.st == ST_RUN) begin
      next_r.adc_was_off = 1'b0;
    end

    // axi write channel capture in either order
    if (s_axi_awvalid && !r.awok) begin
      next_r.awok = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.wok) begin
      next_r.wok = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.awok && r.wok && !r.bvalid) begin
      wb = r.wstrb[0] ? r.wdata[7:0] : 8'h00;
      next_r.bvalid = 1'b1;
      next_r.bresp = AXI_OKAY;
      if (r.wstrb[0]) begin
        case (r.awaddr)
          ADDR_SLEEP_CTRL: next_r.sleep_ctrl = wb & SLEEP_CTRL_MASK; // [RULE22]
          ADDR_POWER_RED: next_r.power_red = wb & POWER_RED_MASK; // [RULE10] [RULE11]
          ADDR_INDIS_LO: next_r.indis_lo = wb; // [RULE20]
          ADDR_INDIS_HI: next_r.indis_hi = wb; // [RULE20]
          ADDR_ANALOG_CFG: next_r.analog_cfg = wb & ANALOG_CFG_MASK;
          ADDR_WAKE_CFG: next_r.wake_cfg = wb[3:0];
          ADDR_STATUS: next_r.bresp = AXI_OKAY;
          default: next_r.bresp = AXI_SLVERR;
        endcase
      end
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
      next_r.awok = 1'b0;
      next_r.wok = 1'b0;
    end

    // axi read
    if (s_axi_arvalid && !r.rvalid) begin
      next_r.rresp = AXI_OKAY;
      case (s_axi_araddr)
        ADDR_SLEEP_CTRL: rd = {24'h000000, r.sleep_ctrl & SLEEP_CTRL_MASK}; // [RULE22]
        ADDR_POWER_RED: rd = {24'h000000, r.power_red};
        ADDR_INDIS_LO: rd = {24'h000000, r.indis_lo};
        ADDR_INDIS_HI: rd = {24'h000000, r.indis_hi};
        ADDR_ANALOG_CFG: rd = {24'h000000, r.analog_cfg};
        ADDR_WAKE_CFG: rd = {28'h0000000, r.wake_cfg};
        ADDR_STATUS: rd = {24'h000000, r.irq_wake, r.adc_was_off, r.mode, 2'b00, r.st};
        default: next_r.rresp = AXI_SLVERR;
      endcase
      next_r.rdata = rd;
      next_r.rvalid = 1'b1;
    end else if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.st <= ST_RUN;
      r.sleep_ctrl <= RESET_BYTE;
      r.power_red <= RESET_BYTE;
      r.wake_cfg <= WAKE_CFG_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !r.awok;
  assign s_axi_wready = !r.wok;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  assign core_halt = (r.st != ST_RUN);
  assign core_irq_resume = (r.st == ST_HALT) && (r.halt_cnt == 3'h1) && r.irq_wake; // [RULE25]
  // debug link keeps the oscillator alive at the cost of sleep current
  assign osc_enable = !deep || debug_link_enable_config; // [RULE2] [RULE21]
  assign cpu_clk_en = !(asleep || r.st == ST_WAKE);
  assign io_clk_en = !(asleep && r.mode != SM_IDLE) && r.st != ST_WAKE; // [RULE2]
  assign adc_clk_en = !deep && r.st != ST_WAKE; // [RULE2] [RULE9]
  assign async_timer_clock_en = !deep || (r.mode == SM_PSAVE && timer0_async_select); // [RULE9]
  // gating only bites in active and idle; deeper modes already stop io clock
  assign periph_clk_en = ~r.power_red[5:0] & {NUM_PERIPH{io_clk_en}}; // [RULE10] [RULE13]
  assign periph_access_en = ~r.power_red[5:0]; // [RULE10]
  assign adc_enable = r.analog_cfg[ACFG_ADC_EN]; // [RULE14]
  assign adc_extended_conv = r.adc_was_off && r.analog_cfg[ACFG_ADC_EN]; // [RULE14]
  assign cmp_enable = r.analog_cfg[ACFG_CMP_EN] && !deep; // [RULE15]
  assign vref_enable = brownout_level_config || r.analog_cfg[ACFG_ADC_EN]
                       || (r.analog_cfg[ACFG_CMP_EN] && r.analog_cfg[ACFG_CMP_IREF]); // [RULE15] [RULE16]
  assign brownout_enable = brownout_level_config; // [RULE17]
  assign watchdog_run = watchdog_enable; // [RULE18]
  assign input_buf_en = io_clk_en || adc_clk_en; // [RULE19]
  assign wake_pin_buf_en = 1'b1; // [RULE19]
  assign input_disable_lo = r.indis_lo; // [RULE20]
  assign input_disable_hi = r.indis_hi; // [RULE20]

endmodule

// File: tb/smpc_ctrl_chk.sv
`timescale 1ns/1ps
module smpc_ctrl_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // core side
  input wire logic sleep_instr,
  input wire logic core_halt,
  input wire logic core_irq_resume,
  // straps
  input wire logic brownout_level_config,
  input wire logic debug_link_enable_config,
  input wire logic watchdog_enable,
  // clock enables
  input wire logic osc_enable,
  input wire logic cpu_clk_en,
  input wire logic io_clk_en,
  input wire logic adc_clk_en,
  // analogue and pins
  input wire logic adc_enable,
  input wire logic cmp_enable,
  input wire logic vref_enable,
  input wire logic brownout_enable,
  input wire logic watchdog_run,
  input wire logic input_buf_en,
  input wire logic wake_pin_buf_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_release;
    core_halt ##1 !core_halt;
  endsequence
  sequence s_held;
    core_halt [*4];
  endsequence
  a_resume_exit: assert property (core_irq_resume |-> s_release)
    else $error("resume pulse off the halt end");
  a_halt_span: assert property ($rose(core_halt) |-> s_held)
    else $error("halt shorter than four cycles");
  a_halt_cause: assert property ($rose(core_halt) |-> $past(sleep_instr))
    else $error("halt without sleep");
  a_resume_only: assert property ($fell(core_halt) |-> $past(core_irq_resume))
    else $error("halt ended without resume");
  a_osc_gates: assert property (!osc_enable |-> !(cpu_clk_en | io_clk_en | adc_clk_en))
    else $error("clock runs with oscillator off");
  a_debug_osc: assert property (debug_link_enable_config && core_halt |-> osc_enable)
    else $error("oscillator off under debug");
  a_wdt_runs: assert property (watchdog_enable |-> watchdog_run)
    else $error("watchdog stopped");
  a_bod_kept: assert property (brownout_level_config |-> brownout_enable)
    else $error("brown-out detector off");
  a_vref_need: assert property (brownout_enable | cmp_enable | adc_enable |-> vref_enable)
    else $error("reference off while needed");
  a_buf_off: assert property (!io_clk_en && !adc_clk_en |-> !input_buf_en && wake_pin_buf_en)
    else $error("input buffer state wrong");
endmodule
bind smpc_ctrl smpc_ctrl_chk smpc_ctrl_chk_inst (.*);

// File: tb/smpc_core_model.sv
`timescale 1ns/1ps
module smpc_core_model (
  // clock
  input wire logic aclk,
  // bench request
  input wire logic go,
  // design side
  input wire logic core_halt,
  input wire logic core_irq_resume,
  output logic sleep_instr,
  output int resumes
);
  initial begin
    sleep_instr = 1'b0;
    resumes = 0;
  end
  // a halted core executes nothing, so no sleep is issued then
  always @(posedge aclk) begin
    sleep_instr <= go && !core_halt && !sleep_instr;
    if (core_irq_resume) resumes <= resumes + 1;
  end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import smpc_pkg::*;
  logic aclk = 0, aresetn = 0, sleep_go = 0, global_irq_enable = 0, debug_link_enable_config = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, input_disable_lo, input_disable_hi;
  logic [8:0] wk = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF, clock_select_config = 4'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, timer0_irq_mask = 0, timer0_event = 0;
  logic s_axi_rvalid, sleep_instr, core_halt, core_irq_resume, timer0_async_select = 1;
  logic brownout_level_config = 1, watchdog_enable = 1, osc_enable, cpu_clk_en, io_clk_en;
  logic adc_clk_en, async_timer_clock_en, adc_enable, adc_extended_conv, cmp_enable;
  logic vref_enable, brownout_enable, watchdog_run, input_buf_en, wake_pin_buf_en;
  logic [5:0] periph_clk_en, periph_access_en;
  wire ext_reset_req = wk[0], watchdog_reset_req = wk[1], watchdog_irq = wk[2];
  wire brownout_reset_req = wk[3], serial_start_irq = wk[4], ext_irq_line_a = wk[5];
  wire ext_irq_line_b = wk[6], pin_change_irq = wk[7], other_irq = wk[8];
  int miscompares = 0, comparisons = 0, resumes, n0, n1;
  smpc_ctrl smpc_ctrl_inst (.*);
  smpc_core_model smpc_core_model_inst (.aclk(aclk), .go(sleep_go), .core_halt(core_halt),
    .core_irq_resume(core_irq_resume), .sleep_instr(sleep_instr), .resumes(resumes));
  always #50 aclk = ~aclk;
  // ----
  // bus and check tasks
  // ----
  task automatic final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tmo;
    miscompares++;
    final_report;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [2:0] hs;
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(negedge aclk);
      n++;
      hs = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid};
      @(posedge aclk);
      if (hs[2]) s_axi_awvalid <= 0;
      if (hs[1]) s_axi_wvalid <= 0;
    end while (!hs[0] && n < 50);
    s_axi_bready <= 0;
    if (!hs[0]) tmo();
    @(posedge aclk);
  endtask
  task automatic rdr(input logic [7:0] a);
    logic [1:0] hs;
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(negedge aclk);
      n++;
      hs = {s_axi_arvalid & s_axi_arready, s_axi_rvalid};
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (hs[1]) s_axi_arvalid <= 0;
    end while (!hs[0] && n < 50);
    s_axi_rready <= 0;
    if (!hs[0]) tmo();
    @(posedge aclk);
  endtask
  task automatic slp(input logic [1:0] m, input logic se);
    wr(ADDR_SLEEP_CTRL, {29'h0, m, se});
    sleep_go <= 1;
    @(posedge aclk);
    sleep_go <= 0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic wt(output int n);
    n = 0;
    while (core_halt && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    if (core_halt) tmo();
  endtask
  // wake level held four cycles, past the two-flop synchroniser
  task automatic wake(input int s, output int n);
    wk[s] <= 1;
    repeat (4) @(posedge aclk);
    wk <= 0;
    wt(n);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    wr(ADDR_SLEEP_CTRL, 32'hFF);
    rdr(ADDR_SLEEP_CTRL);
    chk("sleep_ctrl", rd, 32'h07);
    rdr(8'h1C);
    chk("unmapped", rs, AXI_SLVERR);
    slp(SM_PDOWN, 0);
    chk("no_sleep", core_halt, 0);
    $display("test registers done");
    wr(ADDR_ANALOG_CFG, 32'h3);
    for (int i = 0; i < 8; i++) begin
      clock_select_config <= (i == 1) ? 4'h1 : 4'h0;
      slp(SM_PDOWN, 1);
      chk("pd_clk", {osc_enable, cpu_clk_en, io_clk_en, adc_clk_en, periph_clk_en}, 0);
      chk("pd_ana", {adc_enable, cmp_enable, brownout_enable}, 3'b101);
      wake(i, n1);
      if (i == 0) n0 = n1;
      if (i == 1) chk("wake_delay", n1 - n0, WAKE_BASE_CYC);
    end
    chk("resumed", resumes != 0, 1);
    $display("test power-down done");
    timer0_irq_mask <= 2'b01; // async select set, as power-save wants
    slp(SM_PSAVE, 1);
    chk("ps_clk", {osc_enable, async_timer_clock_en}, 2'b01);
    timer0_event <= 2'b01;
    repeat (30) @(posedge aclk);
    chk("ps_gie", core_halt, 1);
    global_irq_enable <= 1;
    wt(n0);
    timer0_event <= 0;
    timer0_irq_mask <= 2'b10;
    debug_link_enable_config <= 1;
    slp(SM_PSAVE, 1);
    chk("dbg_osc", osc_enable, 1);
    timer0_event <= 2'b10;
    wt(n0);
    timer0_event <= 0;
    debug_link_enable_config <= 0;
    $display("test power-save done");
    slp(SM_IDLE, 1);
    chk("idle", {cpu_clk_en, io_clk_en, adc_clk_en}, 3'b011);
    wake(8, n0);
    slp(SM_ADC_NR, 1);
    chk("noise", {cpu_clk_en, io_clk_en, adc_clk_en}, 3'b001);
    wake(7, n0);
    // peripheral assumed idle before its clock is gated
    wr(ADDR_POWER_RED, 32'h3F);
    chk("gated", {periph_clk_en, periph_access_en}, 0);
    wr(ADDR_POWER_RED, 32'h0);
    chk("ungated", {periph_clk_en, periph_access_en}, 12'hFFF);
    wr(ADDR_INDIS_LO, 32'hA5);
    wr(ADDR_INDIS_HI, 32'h5A);
    chk("indis", {input_disable_hi, input_disable_lo}, 16'h5AA5);
    wr(ADDR_ANALOG_CFG, 32'h0);
    wr(ADDR_ANALOG_CFG, 32'h1);
    chk("ext_conv", adc_extended_conv, 1);
    $display("test peripherals done");
    final_report;
  end
endmodule
